// ===== hw/motor_register_command_interface.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Mode zero keeps motor passive, else active
// - Mode one runs velocity with acceleration ramp
// - Mode two positions to target, then holds
// - Velocity is counts per sample, 2.77 per rpm
// - Torque 1023 equals 300 percent peak
// - Error in RUN state stops motor, cause in status
// - Explicit access: class 0x64, 32-bit words
// - Command 2 to 211 saves, then resets
// - Power-up loads single stored configuration
// - Readbacks: position, velocity, load, follow error
// - Cyclic words map registers, mode first
// - Network settings not reachable by messages
// - Status always in cyclic read words
module motor_register_command_interface
	import motor_reg_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	// Explicit single-register messages
	input  wire logic             expValid,
	input  wire logic             expWrite,
	input  wire logic [7:0]       expClass,
	input  wire logic [7:0]       expInstance,
	input  wire logic [31:0]      expWdata,
	output logic                  expReady,
	output logic                  expRespValid,
	output logic      [31:0]      expRdata,
	output logic                  expRespError,
	// Cyclic assembly exchange
	input  wire logic             cycStrobe,
	input  wire logic [4:0][31:0] cycWrWords,
	output logic      [4:0][31:0] cycRdWords,
	// Motion loop feedback
	input  wire logic [31:0]      actualPosition,
	input  wire logic [31:0]      actualVelocity,
	input  wire logic [31:0]      meanMotorLoad,
	input  wire logic [31:0]      followError,
	input  wire logic             accelerating,
	input  wire logic             decelerating,
	input  wire logic             errorEvent,
	input  wire logic [3:0]       errorCause,
	// Motion loop commands
	output logic                  motorEnable,
	output logic                  velocityMode,
	output logic                  positionMode,
	output logic      [31:0]      velocityCmd,
	output logic      [31:0]      accelCmd,
	output logic      [31:0]      positionCmd,
	output logic      [9:0]       torqueLimit,
	output logic                  selfReset
);

	// ****************************************
	// State
	// ****************************************

	typedef struct packed {
		seq_t             seq;       // Sequencer
		logic [2:0]       idx;       // Load or save slot
		logic [4:0][31:0] work;      // Working registers
		logic [3:0]       cause;     // Last error cause
		logic             errFlag;   // Error latched
		logic [4:0][31:0] pend;      // Cyclic words waiting
		logic             pendValid; // Pending words present
		logic [4:0][31:0] cycRd;     // Cyclic read words
		logic             respValid; // Explicit answer pulse
		logic [31:0]      respData;  // Explicit read data
		logic             respErr;   // Explicit refusal
		logic             reboot;    // Self reset pulse
	} ctrl_t;

	ctrl_t ctrl_r;           // Registered state
	ctrl_t ctrl_nxt;         // Next state
	logic [31:0] flashRd;    // Store read data
	logic        flashWr;    // Store write strobe
	logic [31:0] statusWord; // Live status word
	logic        inPosition; // Target reached
	logic [31:0] readVal;    // Decoded read value
	logic        readOk;     // Instance is readable
	logic        writeOk;    // Instance is writable
	logic [2:0]  writeSlot;  // Slot of written register
	logic        modeLegal;  // Written mode supported

	// ****************************************
	// Configuration store
	// ****************************************

	// Store only written while saving
	assign flashWr = (ctrl_r.seq == SAVE);

	config_flash store (
		.clk    (clk),
		.wrEn   (flashWr),
		.addr   (ctrl_r.idx),
		.wrData (ctrl_r.work[ctrl_r.idx]),
		.rdData (flashRd)
	);

	// ****************************************
	// Status and decode
	// ****************************************

	// Status word from latched cause and live motion
	always_comb begin
		inPosition = (ctrl_r.work[SLOT_MODE] == MODE_POSITION)
			&& (actualPosition == ctrl_r.work[SLOT_POS]);
		statusWord = 32'h0000_0000;
		statusWord[ST_CAUSE_LSB +: 4] = ctrl_r.cause;
		statusWord[ST_IN_POS] = inPosition;
		statusWord[ST_ACCEL] = accelerating;
		statusWord[ST_DECEL] = decelerating;
		statusWord[ST_ERROR] = ctrl_r.errFlag;
	end

	// Instance decode; unlisted instances, network settings among them, refused
	always_comb begin
		readVal = 32'h0000_0000;
		readOk = 1'b1;
		writeOk = 1'b1;
		writeSlot = SLOT_MODE;
		unique case (expInstance)
			REG_MODE: begin
				readVal = ctrl_r.work[SLOT_MODE];
			end
			REG_REQ_POS: begin
				readVal = ctrl_r.work[SLOT_POS];
				writeSlot = SLOT_POS;
			end
			REG_REQ_VEL: begin
				readVal = ctrl_r.work[SLOT_VEL];
				writeSlot = SLOT_VEL;
			end
			REG_REQ_ACC: begin
				readVal = ctrl_r.work[SLOT_ACC];
				writeSlot = SLOT_ACC;
			end
			REG_REQ_TRQ: begin
				readVal = ctrl_r.work[SLOT_TRQ];
				writeSlot = SLOT_TRQ;
			end
			REG_ACT_POS: begin
				readVal = actualPosition;
				writeOk = 1'b0;
			end
			REG_ACT_VEL: begin
				readVal = actualVelocity;
				writeOk = 1'b0;
			end
			REG_LOAD_MEAN: begin
				readVal = meanMotorLoad;
				writeOk = 1'b0;
			end
			REG_FOLLOW: begin
				readVal = followError;
				writeOk = 1'b0;
			end
			REG_STATUS: begin
				readVal = statusWord;
				writeOk = 1'b0;
			end
			REG_COMMAND: begin
				readOk = 1'b0;
			end
			default: begin
				readOk = 1'b0;
				writeOk = 1'b0;
			end
		endcase
		modeLegal = (expWdata == MODE_PASSIVE) || (expWdata == MODE_VELOCITY)
			|| (expWdata == MODE_POSITION);
	end

	// ****************************************
	// Next state
	// ****************************************

	// Sequencer, cyclic exchange and explicit messages
	always_comb begin
		ctrl_nxt = ctrl_r;
		ctrl_nxt.respValid = 1'b0;
		ctrl_nxt.reboot = 1'b0;
		unique case (ctrl_r.seq)
			LOAD: begin
				// Address runs one ahead of the registered data
				if (ctrl_r.idx != 3'h0) begin
					ctrl_nxt.work[ctrl_r.idx - 3'h1] = flashRd;
				end
				if (ctrl_r.idx == LOAD_LAST) begin
					ctrl_nxt.seq = RUN;
					ctrl_nxt.idx = 3'h0;
				end else begin
					ctrl_nxt.idx = ctrl_r.idx + 3'h1;
				end
			end
			SAVE: begin
				// Every working register written once
				if (ctrl_r.idx == SLOT_TRQ) begin
					ctrl_nxt.seq = RESTART;
					ctrl_nxt.idx = 3'h0;
				end else begin
					ctrl_nxt.idx = ctrl_r.idx + 3'h1;
				end
			end
			RESTART: begin
				// Pulse reset out, drop errors, reload
				ctrl_nxt.reboot = 1'b1;
				ctrl_nxt.cause = 4'h0;
				ctrl_nxt.errFlag = 1'b0;
				ctrl_nxt.pendValid = 1'b0;
				ctrl_nxt.seq = LOAD;
			end
			RUN: begin
				// Cyclic words take effect at the following exchange
				if (cycStrobe) begin
					if (ctrl_r.pendValid) begin
						ctrl_nxt.work = ctrl_r.pend;
					end
					ctrl_nxt.pend = cycWrWords;
					ctrl_nxt.pendValid = 1'b1;
				end
				// Explicit writes act at once, over cyclic
				if (expValid) begin
					ctrl_nxt.respValid = 1'b1;
					ctrl_nxt.respData = 32'h0000_0000;
					ctrl_nxt.respErr = 1'b0;
					if (expClass != MOTOR_CLASS) begin
						ctrl_nxt.respErr = 1'b1;
					end else if (!expWrite) begin
						ctrl_nxt.respData = readVal;
						ctrl_nxt.respErr = !readOk;
					end else if (expInstance == REG_COMMAND) begin
						if (expWdata == CMD_SAVE_FLASH) begin
							ctrl_nxt.seq = SAVE;
							ctrl_nxt.idx = 3'h0;
						end
					end else if (!writeOk) begin
						ctrl_nxt.respErr = 1'b1;
					end else if ((writeSlot == SLOT_MODE) && !modeLegal) begin
						ctrl_nxt.respErr = 1'b1;
					end else begin
						ctrl_nxt.work[writeSlot] = expWdata;
						if ((writeSlot == SLOT_MODE) && (expWdata != MODE_PASSIVE)) begin
							ctrl_nxt.errFlag = 1'b0;
						end
					end
				end
				// Errors stop the motor; set wins over clear
				if (errorEvent) begin
					ctrl_nxt.work[SLOT_MODE] = MODE_PASSIVE;
					ctrl_nxt.cause = errorCause;
					ctrl_nxt.errFlag = 1'b1;
				end
			end
		endcase
		// Read words fixed: status in the last word
		if (cycStrobe) begin
			ctrl_nxt.cycRd[0] = ctrl_r.work[SLOT_MODE];
			ctrl_nxt.cycRd[1] = actualPosition;
			ctrl_nxt.cycRd[2] = actualVelocity;
			ctrl_nxt.cycRd[3] = followError;
			ctrl_nxt.cycRd[4] = statusWord;
		end
	end

	// Register stage, synchronous reset loads from store
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************

	assign expReady = (ctrl_r.seq == RUN);
	assign expRespValid = ctrl_r.respValid;
	assign expRdata = ctrl_r.respData;
	assign expRespError = ctrl_r.respErr;
	assign cycRdWords = ctrl_r.cycRd;
	assign selfReset = ctrl_r.reboot;
	// Zero mode de-energizes the axle
	assign motorEnable = (ctrl_r.work[SLOT_MODE] != MODE_PASSIVE);
	assign velocityMode = (ctrl_r.work[SLOT_MODE] == MODE_VELOCITY);
	assign positionMode = (ctrl_r.work[SLOT_MODE] == MODE_POSITION);
	// Velocity passed on unscaled, counts per sample
	assign velocityCmd = ctrl_r.work[SLOT_VEL];
	assign accelCmd = ctrl_r.work[SLOT_ACC];
	assign positionCmd = ctrl_r.work[SLOT_POS];
	// Full scale clamps at peak torque
	assign torqueLimit = (ctrl_r.work[SLOT_TRQ] > TORQUE_FULL_SCALE) ? 10'h3FF
		: ctrl_r.work[SLOT_TRQ][9:0];

	// ****************************************
	// Checks
	// ****************************************

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_passive_drive: assert property (
		(ctrl_r.work[SLOT_MODE] == MODE_PASSIVE) |-> !motorEnable && !velocityMode)
		else $error("motor enabled in passive mode");

	chk_velocity_cmd: assert property (
		expValid && expReady && expWrite && (expClass == MOTOR_CLASS)
		&& (expInstance == REG_MODE) && (expWdata == MODE_VELOCITY) && !errorEvent
		|=> velocityMode && motorEnable)
		else $error("velocity mode not entered");

	chk_position_hold: assert property (
		positionMode && (actualPosition == positionCmd) && cycStrobe
		|=> cycRdWords[4][ST_IN_POS])
		else $error("in position not reported");

	chk_torque_clamp: assert property (
		(ctrl_r.work[SLOT_TRQ] >= TORQUE_FULL_SCALE) |-> (torqueLimit == 10'h3FF))
		else $error("torque not clamped");

	chk_error_stop: assert property (
		errorEvent && expReady |=> !motorEnable && ctrl_r.errFlag
		&& (ctrl_r.cause == $past(errorCause)))
		else $error("error did not stop motor");

	chk_motion_flags: assert property (
		cycStrobe |=> (cycRdWords[4][ST_ACCEL] == $past(accelerating))
		&& (cycRdWords[4][ST_DECEL] == $past(decelerating)))
		else $error("motion flags wrong");

	chk_class_refused: assert property (
		expValid && expReady && (expClass != MOTOR_CLASS) |=> expRespValid && expRespError)
		else $error("wrong class accepted");

	chk_save_reset: assert property (
		expValid && expReady && expWrite && (expClass == MOTOR_CLASS)
		&& (expInstance == REG_COMMAND) && (expWdata == CMD_SAVE_FLASH)
		|-> ##[6:7] selfReset)
		else $error("save did not reset");

	chk_boot_load: assert property (
		selfReset |-> !expReady [*6] ##1 expReady)
		else $error("reload length wrong");

	chk_net_refused: assert property (
		expValid && expReady && !readOk && !expWrite |=> expRespError)
		else $error("unmapped instance answered");

	chk_cyclic_late: assert property (
		cycStrobe && expReady && !ctrl_r.pendValid && !expValid && !errorEvent
		|=> $stable(ctrl_r.work))
		else $error("cyclic write took effect early");

	cov_velocity: cover property (velocityMode && motorEnable);
	cov_save: cover property (selfReset);
	cov_error: cover property (errorEvent && motorEnable);

endmodule
`default_nettype wire

// ===== hw/motor_reg_pkg.sv
// ****************************************
// Register map, modes and sequencing constants
// ****************************************
package motor_reg_pkg;

	// Register instance numbers, one 32-bit word each
	localparam logic [7:0] REG_MODE      = 8'h02;
	localparam logic [7:0] REG_REQ_POS   = 8'h03;
	localparam logic [7:0] REG_REQ_VEL   = 8'h05;
	localparam logic [7:0] REG_REQ_ACC   = 8'h06;
	localparam logic [7:0] REG_REQ_TRQ   = 8'h07;
	localparam logic [7:0] REG_ACT_POS   = 8'h0A;
	localparam logic [7:0] REG_ACT_VEL   = 8'h0C;
	localparam logic [7:0] REG_LOAD_MEAN = 8'h10;
	localparam logic [7:0] REG_FOLLOW    = 8'h14;
	localparam logic [7:0] REG_STATUS    = 8'h23;
	localparam logic [7:0] REG_COMMAND   = 8'hD3;

	// Explicit message class for motor registers
	localparam logic [7:0] MOTOR_CLASS = 8'h64;

	// Operating modes
	localparam logic [31:0] MODE_PASSIVE  = 32'h0000_0000;
	localparam logic [31:0] MODE_VELOCITY = 32'h0000_0001;
	localparam logic [31:0] MODE_POSITION = 32'h0000_0002;

	// Command register value that saves to flash
	localparam logic [31:0] CMD_SAVE_FLASH = 32'h0000_0002;

	// Slot numbers of working registers, also cyclic word and flash slot
	localparam int WORK_WORDS = 5;
	localparam logic [2:0] SLOT_MODE = 3'h0;
	localparam logic [2:0] SLOT_POS  = 3'h1;
	localparam logic [2:0] SLOT_VEL  = 3'h2;
	localparam logic [2:0] SLOT_ACC  = 3'h3;
	localparam logic [2:0] SLOT_TRQ  = 3'h4;
	localparam logic [2:0] LOAD_LAST = 3'h5;

	// Status word fields
	localparam int ST_CAUSE_LSB = 0;
	localparam int ST_IN_POS    = 4;
	localparam int ST_ACCEL     = 5;
	localparam int ST_DECEL     = 6;
	localparam int ST_ERROR     = 7;

	// Torque full scale (peak torque, 300 percent of rated)
	localparam logic [31:0] TORQUE_FULL_SCALE = 32'h0000_03FF;
	localparam int TORQUE_PEAK_PERCENT = 300;

	// Velocity unit: counts per sample per rpm, times 100
	localparam int VEL_COUNTS_PER_RPM_X100 = 277;

	// Sequencer states
	typedef enum logic [1:0] {LOAD, RUN, SAVE, RESTART} seq_t;

endpackage

// ===== hw/config_flash.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Nonvolatile configuration store, registered read
// ****************************************
module config_flash (
	input  wire logic        clk,
	input  wire logic        wrEn,
	input  wire logic [2:0]  addr,
	input  wire logic [31:0] wrData,
	output logic      [31:0] rdData
);

	// Contents survive the block reset
	logic [31:0] cells [0:7];

	// Factory contents all zero: passive start
	initial begin
		for (int i = 0; i < 8; i++) begin
			cells[i] = 32'h0000_0000;
		end
	end

	// Write port and registered read port
	always_ff @(posedge clk) begin
		if (wrEn) begin
			cells[addr] <= wrData;
		end
		rdData <= cells[addr];
	end

endmodule
`default_nettype wire

// ===== bench/scanner_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Network scanner: explicit and cyclic requests
// ****************************************
module scanner_model (
	input  wire logic             clk,
	input  wire logic             expReady,
	input  wire logic             expRespValid,
	input  wire logic [31:0]      expRdata,
	input  wire logic             expRespError,
	output logic                  expValid,
	output logic                  expWrite,
	output logic      [7:0]       expClass,
	output logic      [7:0]       expInstance,
	output logic      [31:0]      expWdata,
	output logic                  cycStrobe,
	output logic      [4:0][31:0] cycWrWords
);
	// Idle lines at time zero
	initial begin
		expValid = 1'h0;
		expWrite = 1'h0;
		expClass = 8'h00;
		expInstance = 8'h00;
		expWdata = 32'h0;
		cycStrobe = 1'h0;
		cycWrWords = '0;
	end
	// One explicit message, held until the block takes it
	task automatic access(input logic wr, input logic [7:0] cls, input logic [7:0] inst,
		input logic [31:0] data, output logic ok, output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(negedge clk);
		expValid = 1'h1;
		expWrite = wr;
		expClass = cls;
		expInstance = inst;
		expWdata = data;
		// Ready is settled at the falling edge and holds over the next rising one
		while (expReady !== 1'h1 && n < 100) begin
			n++;
			@(negedge clk);
		end
		// Taking edge, then answer stands in the following cycle
		@(posedge clk);
		@(negedge clk);
		ok = expRespValid;
		rd = expRdata;
		err = expRespError;
		// Released lines stop showing the old request
		expValid = 1'h0;
		expWrite = ~wr;
		expInstance = ~inst;
		expWdata = ~data;
	endtask
	// One exchange cycle, mode in the first word
	task automatic exchange(input logic [4:0][31:0] w);
		@(negedge clk);
		cycStrobe = 1'h1;
		cycWrWords = w;
		@(negedge clk);
		cycStrobe = 1'h0;
		cycWrWords = ~w;
	endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp, msg) begin testsRun++; if ((got) !== (exp)) begin errors++; \
	$display("unexpected at %0t: %s", $time, msg); end end
module testbench
	import motor_reg_pkg::*;
;
	// ****************************************
	// Signals
	// ****************************************
	logic             clk, rst, expValid, expWrite, expReady, expRespValid, expRespError;
	logic             cycStrobe, accelerating, decelerating, errorEvent, motorEnable;
	logic             velocityMode, positionMode, selfReset;
	logic [7:0]       expClass, expInstance;
	logic [31:0]      expWdata, expRdata, actualPosition, actualVelocity, meanMotorLoad;
	logic [31:0]      followError, velocityCmd, accelCmd, positionCmd, rd;
	logic [3:0]       errorCause;
	logic [9:0]       torqueLimit;
	logic [4:0][31:0] cycWrWords, cycRdWords, w;
	int               errors, testsRun, cycles;
	// ****************************************
	// Block and scanner
	// ****************************************
	motor_register_command_interface i_motor_register_command_interface (
		.clk(clk), .rst(rst), .expValid(expValid), .expWrite(expWrite), .expClass(expClass),
		.expInstance(expInstance), .expWdata(expWdata), .expReady(expReady),
		.expRespValid(expRespValid), .expRdata(expRdata), .expRespError(expRespError),
		.cycStrobe(cycStrobe), .cycWrWords(cycWrWords), .cycRdWords(cycRdWords),
		.actualPosition(actualPosition), .actualVelocity(actualVelocity),
		.meanMotorLoad(meanMotorLoad), .followError(followError),
		.accelerating(accelerating), .decelerating(decelerating), .errorEvent(errorEvent),
		.errorCause(errorCause), .motorEnable(motorEnable), .velocityMode(velocityMode),
		.positionMode(positionMode), .velocityCmd(velocityCmd), .accelCmd(accelCmd),
		.positionCmd(positionCmd), .torqueLimit(torqueLimit), .selfReset(selfReset));
	scanner_model i_scanner_model (
		.clk(clk), .expReady(expReady), .expRespValid(expRespValid), .expRdata(expRdata),
		.expRespError(expRespError), .expValid(expValid), .expWrite(expWrite),
		.expClass(expClass), .expInstance(expInstance), .expWdata(expWdata),
		.cycStrobe(cycStrobe), .cycWrWords(cycWrWords));
	// Clock, 40 ns period
	initial clk = 1'h0;
	always #20 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			final_report();
		end
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	// Verdict and end of run
	task automatic final_report();
		if (errors == 0 && testsRun > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Explicit access with answer code check
	task automatic acc(input logic wr, input logic [7:0] inst, input logic [31:0] data,
		input logic expErr, input logic [7:0] cls = MOTOR_CLASS);
		logic ok, err;
		i_scanner_model.access(wr, cls, inst, data, ok, rd, err);
		`CHECK(ok, 1'h1, "no answer")
		`CHECK(err, expErr, "answer code")
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	// Ready exactly six edges after reset, store empty
	task automatic t_reset();
		repeat (5) @(negedge clk);
		`CHECK(expReady, 1'h0, "ready early")
		@(negedge clk);
		`CHECK(expReady, 1'h1, "ready late")
		`CHECK(velocityCmd, 32'h0, "loaded velocity")
	endtask
	// Profile registers, torque at full scale
	task automatic t_profile();
		acc(1'h1, REG_REQ_VEL, 32'(1000 * VEL_COUNTS_PER_RPM_X100 / 100), 1'h0);
		`CHECK(velocityCmd, 32'h0000_0AD2, "velocity")
		acc(1'h1, REG_REQ_ACC, 32'h0000_0048, 1'h0);
		`CHECK(accelCmd, 32'h0000_0048, "accel")
		acc(1'h1, REG_REQ_TRQ, 32'h0000_03FF, 1'h0);
		`CHECK(torqueLimit, 10'h3FF, "peak torque")
		acc(1'h1, REG_REQ_TRQ, 32'h0000_00FF, 1'h0);
		`CHECK(torqueLimit, 10'h0FF, "torque")
		acc(1'h0, REG_REQ_VEL, 32'h0, 1'h0);
		`CHECK(rd, 32'h0000_0AD2, "velocity read")
	endtask
	// Every mode, ending passive
	task automatic t_modes();
		acc(1'h1, REG_REQ_POS, 32'h0001_2345, 1'h0);
		`CHECK(positionCmd, 32'h0001_2345, "target")
		for (int m = 2; m >= 0; m--) begin
			acc(1'h1, REG_MODE, 32'(m), 1'h0);
			`CHECK(motorEnable, m != 0, "enable")
			`CHECK(velocityMode, m == 1, "velocity mode")
			`CHECK(positionMode, m == 2, "position mode")
		end
	endtask
	// Refused messages and an ignored non-save command
	task automatic t_refuse();
		acc(1'h0, REG_MODE, 32'h0, 1'h1, 8'h65);
		acc(1'h1, REG_ACT_POS, 32'h0000_0005, 1'h1);
		acc(1'h0, 8'h01, 32'h0, 1'h1);
		acc(1'h0, REG_COMMAND, 32'h0, 1'h1);
		acc(1'h1, REG_MODE, 32'h0000_0003, 1'h1);
		acc(1'h1, REG_COMMAND, 32'h0000_0001, 1'h0);
		`CHECK(motorEnable, 1'h0, "mode kept")
		repeat (10) @(negedge clk);
		`CHECK(expReady, 1'h1, "no save")
	endtask
	// Feedback readbacks
	task automatic t_readback();
		logic [7:0] regs[4] = '{REG_ACT_POS, REG_ACT_VEL, REG_LOAD_MEAN, REG_FOLLOW};
		logic [31:0] vals[4] = '{32'h0001_0000, 32'h0000_0AD2, 32'h0000_0033, 32'hFFFF_FFF0};
		@(negedge clk);
		actualPosition = vals[0];
		actualVelocity = vals[1];
		meanMotorLoad = vals[2];
		followError = vals[3];
		for (int i = 0; i < 4; i++) begin
			acc(1'h0, regs[i], 32'h0, 1'h0);
			`CHECK(rd, vals[i], "readback")
		end
	endtask
	// Cyclic words applied one exchange late, status flags
	task automatic t_cyclic();
		w = {32'h0000_00FF, 32'h0000_0048, 32'h0000_0AD2, 32'h0000_1234, MODE_POSITION};
		accelerating = 1'h1;
		i_scanner_model.exchange(w);
		`CHECK(cycRdWords[0], MODE_PASSIVE, "mode word")
		`CHECK(cycRdWords[1], 32'h0001_0000, "position word")
		`CHECK(cycRdWords[4][6:5], 2'h1, "accel flag")
		`CHECK(positionCmd, 32'h0001_2345, "applied early")
		accelerating = 1'h0;
		decelerating = 1'h1;
		i_scanner_model.exchange(w);
		`CHECK(cycRdWords[4][6:5], 2'h2, "decel flag")
		`CHECK(positionCmd, 32'h0000_1234, "cyclic target")
		`CHECK(positionMode, 1'h1, "cyclic mode")
		// Axle reaches the cyclic target
		actualPosition = 32'h0000_1234;
		i_scanner_model.exchange(w);
		`CHECK(cycRdWords[4][ST_IN_POS], 1'h1, "in position flag")
	endtask
	// Error stops motor, error flag kept until non-passive mode written
	task automatic t_error();
		@(negedge clk);
		errorEvent = 1'h1;
		errorCause = 4'h9;
		@(negedge clk);
		errorEvent = 1'h0;
		`CHECK(motorEnable, 1'h0, "error stop")
		acc(1'h0, REG_STATUS, 32'h0, 1'h0);
		`CHECK({rd[7], rd[3:0]}, 5'h19, "cause")
		acc(1'h1, REG_MODE, MODE_VELOCITY, 1'h0);
		acc(1'h0, REG_STATUS, 32'h0, 1'h0);
		`CHECK(rd[7], 1'h0, "error cleared")
	endtask
	// Save, restart, reload
	task automatic t_save();
		int n;
		acc(1'h1, REG_COMMAND, CMD_SAVE_FLASH, 1'h0);
		n = 0;
		while (selfReset !== 1'h1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		`CHECK(selfReset, 1'h1, "self reset")
		`CHECK(expReady, 1'h0, "ready in restart")
		n = 0;
		while (expReady !== 1'h1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		`CHECK(velocityCmd, 32'h0000_0AD2, "stored velocity")
		`CHECK(positionCmd, 32'h0000_1234, "stored target")
		`CHECK(torqueLimit, 10'h0FF, "stored torque")
		`CHECK(velocityMode, 1'h1, "stored mode")
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst = 1'h1;
		{accelerating, decelerating, errorEvent} = 3'h0;
		errorCause = 4'h0;
		{actualPosition, actualVelocity, meanMotorLoad, followError} = '0;
		repeat (20) @(posedge clk);
		@(negedge clk);
		rst = 1'h0;
		t_reset();
		t_profile();
		t_modes();
		t_refuse();
		t_readback();
		t_cyclic();
		t_error();
		t_save();
		final_report();
	end
endmodule
`default_nettype wire
